// ==== inc/xma_defines.svh ====
// Behaviour
// - far ops address any memory section by full address, ignoring bank selection.
// - add-with-carry sums memory, working and carry; sets OV Z AC C SC.
// - plain add sums memory and working without carry; sets OV Z AC C SC.
// - AND of working and memory to working or memory; only zero flag changes.
// - OR of working and memory to working or memory; only zero flag changes.
// - byte clear writes zero to memory; flags untouched.
// - bit clear zeroes only the chosen memory bit; flags untouched.
// - complement inverts memory to memory or working; updates zero flag.
// - decimal adjust adds 6 per nibble when nibble above 9 or its carry (AC for low, C for high).
// - adjusted value goes to memory; only carry may change.
// - decrement memory to memory or working; updates zero flag.
// - increment memory to memory or working; updates zero flag.
// - move copies memory to working or working to memory; flags untouched.
// - rotate left, old bit 7 into bit 0; flags untouched.
// - rotate left through carry: old carry to bit 0, bit 7 to carry.
// - rotate right, old bit 0 into bit 7; flags untouched.
// - rotate right through carry: old carry to bit 7, bit 0 to carry.
// - subtract-with-borrow: working minus memory minus inverted carry into working.
// - after subtraction carry clear on negative, set on zero or positive.
// - subtract-with-borrow updates OV Z AC C SC and CZ.
`ifndef XMA_DEFINES_SVH
`define XMA_DEFINES_SVH

`define XMA_DATA_W 8
`define XMA_NIB_W 4
`define XMA_MEM_AW 9
`define XMA_WB_AW 8
`define XMA_WB_DW 32

// register byte offsets
`define XMA_OFS_CTRL 8'h00
`define XMA_OFS_ADDR 8'h04
`define XMA_OFS_WREG 8'h08
`define XMA_OFS_FLAGS 8'h0c
`define XMA_OFS_MDATA 8'h10
`define XMA_OFS_STAT 8'h14

// control field layout
`define XMA_CTRL_OP_LSB 0
`define XMA_CTRL_OP_W 5
`define XMA_CTRL_BIT_LSB 5
`define XMA_CTRL_BIT_W 3

// reset values
`define XMA_RST_BYTE 8'h00
`define XMA_RST_FLAGS 6'h00

// arithmetic constants
`define XMA_BYTE_ZERO 8'h00
`define XMA_BYTE_ONE 8'h01
`define XMA_BCD_MAX 4'h9
`define XMA_DAA_LO 8'h06
`define XMA_DAA_HI 8'h60

`endif

// ==== inc/xma_pkg.sv ====
`include "xma_defines.svh"

package xma_pkg;

   // operation codes, numbered from zero in this order
   typedef enum logic [`XMA_CTRL_OP_W-1:0] {
      far_add_with_carry_to_working,
      far_add_with_carry_to_memory,
      far_add_to_working,
      far_add_to_memory,
      far_bitwise_conjunction,
      far_bitwise_conjunction_to_memory,
      far_byte_clear,
      far_bit_clear,
      far_invert_in_place,
      far_invert_to_working,
      far_decimal_adjust_to_memory,
      far_decrement_in_place,
      far_decrement_to_working,
      far_increment_in_place,
      far_increment_to_working,
      far_move_to_working,
      far_move_to_memory,
      far_bitwise_disjunction,
      far_bitwise_disjunction_to_memory,
      far_rotate_left,
      far_rotate_left_to_working,
      far_rotate_left_through_carry,
      far_rotate_left_carry_to_working,
      far_rotate_right,
      far_rotate_right_to_working,
      far_rotate_right_through_carry,
      far_rotate_right_carry_to_working,
      far_subtract_with_borrow
   } xma_op_t;

   typedef enum logic [1:0] {
      st_idle,
      st_fetch,
      st_exec
   } xma_state_t;

   // status flags, carry in bit 0
   typedef struct packed {
      logic chained_zero_flag;
      logic signed_result_flag;
      logic overflow_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } xma_flags_t;

   // classic wishbone request
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [`XMA_WB_AW-1:0] adr;
      logic [`XMA_WB_DW-1:0] dat;
   } xma_wb_req_t;

endpackage

// ==== rtl/xma_addsub.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "xma_defines.svh"

module xma_addsub #(
   parameter int W = `XMA_DATA_W
) (
   // operands
   input wire logic [W-1:0] a_i,
   input wire logic [W-1:0] b_i,
   input wire logic cin_i,
   input wire logic sub_i,
   // result and flags
   output logic [W-1:0] res_o,
   output logic c_o,
   output logic ac_o,
   output logic ov_o,
   output logic sc_o
);

   logic [W-1:0] bx;
   logic [W:0] full;
   logic [`XMA_NIB_W:0] nib;

   // subtraction as a + ~b + cin, so carry reads as not-borrow
   assign bx = sub_i ? ~b_i : b_i;
   assign full = {1'b0, a_i} + {1'b0, bx} + {{W{1'b0}}, cin_i};
   assign nib = {1'b0, a_i[`XMA_NIB_W-1:0]} + {1'b0, bx[`XMA_NIB_W-1:0]}
              + {{`XMA_NIB_W{1'b0}}, cin_i};
   assign res_o = full[W-1:0];
   assign c_o = full[W];
   assign ac_o = nib[`XMA_NIB_W];
   // signed overflow and true sign of the result
   assign ov_o = (a_i[W-1] == bx[W-1]) & (res_o[W-1] != a_i[W-1]);
   assign sc_o = ov_o ^ res_o[W-1];

endmodule
`default_nettype wire

// ==== rtl/xma_rotator.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "xma_defines.svh"

module xma_rotator #(
   parameter int W = `XMA_DATA_W
) (
   // operand and control
   input wire logic [W-1:0] d_i,
   input wire logic cin_i,
   input wire logic left_i,
   input wire logic through_i,
   // result
   output logic [W-1:0] res_o,
   output logic cout_o
);

   logic fill_l;
   logic fill_r;

   // through carry takes old carry, plain rotate wraps the far bit
   assign fill_l = through_i ? cin_i : d_i[W-1];
   assign fill_r = through_i ? cin_i : d_i[0];
   assign res_o = left_i ? {d_i[W-2:0], fill_l} : {fill_r, d_i[W-1:1]};
   assign cout_o = left_i ? d_i[W-1] : d_i[0];

endmodule
`default_nettype wire

// ==== rtl/xma_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "xma_defines.svh"

module xma_top #(
   parameter int MEM_AW = `XMA_MEM_AW,
   parameter int W = `XMA_DATA_W
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // wishbone slave
   input wire xma_pkg::xma_wb_req_t wb_req_i,
   output logic [`XMA_WB_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // status
   output logic busy_o,
   output logic done_o
);

   localparam int DW = `XMA_WB_DW;

   // state
   xma_pkg::xma_state_t state;
   xma_pkg::xma_state_t next_state;
   xma_pkg::xma_op_t op;
   xma_pkg::xma_flags_t flags;
   xma_pkg::xma_flags_t next_flags;
   logic [`XMA_CTRL_BIT_W-1:0] bit_idx;
   logic [MEM_AW-1:0] far_addr;
   logic [MEM_AW-1:0] next_far_addr;
   logic [W-1:0] working;
   logic [W-1:0] operand;
   logic [W-1:0] mem [0:(2**MEM_AW)-1];
   logic [W-1:0] mem_rd;

   // bus decode
   logic bus_req;
   logic bus_wr;
   logic idle;
   logic sel_ctrl;
   logic sel_addr;
   logic sel_wreg;
   logic sel_flags;
   logic sel_mdata;
   logic sel_stat;
   logic lane0;
   logic [15:0] lane_mask;
   logic [MEM_AW-1:0] addr_mask;
   logic go;
   logic sw_wreg_wr;
   logic sw_flags_wr;
   logic sw_mem_wr;
   logic [DW-1:0] next_rdata;

   // datapath wires
   logic [W-1:0] res;
   logic to_mem;
   logic to_working;
   logic [W-1:0] as_res;
   logic as_c;
   logic as_ac;
   logic as_ov;
   logic as_sc;
   logic as_cin;
   logic as_sub;
   logic [W-1:0] rot_res;
   logic rot_cout;
   logic rot_left;
   logic rot_through;
   logic res_zero;
   logic daa_lo;
   logic daa_hi;
   logic [W:0] daa_sum;
   logic [W-1:0] daa_add;
   logic [W-1:0] inc_res;
   logic [W-1:0] dec_res;
   logic [W-1:0] bit_mask;
   logic exec;

   // request seen once per transfer; ack drops the cycle after it rose
   assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
   assign bus_wr = bus_req & wb_req_i.we;
   assign idle = (state == xma_pkg::st_idle);
   assign sel_ctrl = (wb_req_i.adr == `XMA_OFS_CTRL);
   assign sel_addr = (wb_req_i.adr == `XMA_OFS_ADDR);
   assign sel_wreg = (wb_req_i.adr == `XMA_OFS_WREG);
   assign sel_flags = (wb_req_i.adr == `XMA_OFS_FLAGS);
   assign sel_mdata = (wb_req_i.adr == `XMA_OFS_MDATA);
   assign sel_stat = (wb_req_i.adr == `XMA_OFS_STAT);
   assign lane0 = wb_req_i.sel[0];
   assign lane_mask = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
   assign addr_mask = lane_mask[MEM_AW-1:0];

   // all writes, the address included, are refused while an op runs,
   // so software cannot race the datapath on working or memory
   assign go = bus_wr & sel_ctrl & lane0 & idle;
   assign sw_wreg_wr = bus_wr & sel_wreg & lane0 & idle;
   assign sw_flags_wr = bus_wr & sel_flags & lane0 & idle;
   assign sw_mem_wr = bus_wr & sel_mdata & lane0 & idle;
   assign next_far_addr = (far_addr & ~addr_mask)
                        | (wb_req_i.dat[MEM_AW-1:0] & addr_mask);

   // read mux, unmapped offsets answer zero
   always_comb begin
      next_rdata = '0;
      if (sel_ctrl) begin
         next_rdata[`XMA_CTRL_OP_LSB +: `XMA_CTRL_OP_W] = op;
         next_rdata[`XMA_CTRL_BIT_LSB +: `XMA_CTRL_BIT_W] = bit_idx;
      end else if (sel_addr) begin
         next_rdata[MEM_AW-1:0] = far_addr;
      end else if (sel_wreg) begin
         next_rdata[W-1:0] = working;
      end else if (sel_flags) begin
         next_rdata[$bits(flags)-1:0] = flags;
      end else if (sel_mdata) begin
         next_rdata[W-1:0] = mem_rd;
      end else if (sel_stat) begin
         next_rdata[0] = ~idle;
      end
   end

   // bus answer, one cycle after the request
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? next_rdata : '0;
      end
   end

   // control registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         op <= xma_pkg::far_add_with_carry_to_working;
         bit_idx <= '0;
         far_addr <= '0;
      end else begin
         if (go) begin
            op <= xma_pkg::xma_op_t'(wb_req_i.dat[`XMA_CTRL_OP_LSB +: `XMA_CTRL_OP_W]);
            bit_idx <= wb_req_i.dat[`XMA_CTRL_BIT_LSB +: `XMA_CTRL_BIT_W];
         end
         if (bus_wr & sel_addr & idle) begin
            far_addr <= next_far_addr;
         end
      end
   end

   // full far address picks section and byte, no bank register involved
   assign mem_rd = mem[far_addr];

   // sequencer: fetch operand, then execute and write back
   always_comb begin
      next_state = state;
      case (state)
         xma_pkg::st_idle: begin
            if (go) begin
               next_state = xma_pkg::st_fetch;
            end
         end
         xma_pkg::st_fetch: begin
            next_state = xma_pkg::st_exec;
         end
         xma_pkg::st_exec: begin
            next_state = xma_pkg::st_idle;
         end
         default: begin
            next_state = xma_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= xma_pkg::st_idle;
         operand <= `XMA_RST_BYTE;
         done_o <= 1'b0;
      end else begin
         state <= next_state;
         done_o <= exec;
         if (state == xma_pkg::st_fetch) begin
            operand <= mem_rd;
         end
      end
   end

   assign exec = (state == xma_pkg::st_exec);
   assign busy_o = ~idle;

   // shared adder: carry-in only for the carry forms
   assign as_sub = (op == xma_pkg::far_subtract_with_borrow);
   assign as_cin = (op == xma_pkg::far_add_to_working)
                 | (op == xma_pkg::far_add_to_memory) ? 1'b0 : flags.carry_flag;

   xma_addsub #(
      .W(W)
   ) u_addsub (
      .a_i(working),
      .b_i(operand),
      .cin_i(as_cin),
      .sub_i(as_sub),
      .res_o(as_res),
      .c_o(as_c),
      .ac_o(as_ac),
      .ov_o(as_ov),
      .sc_o(as_sc)
   );

   assign rot_left = (op == xma_pkg::far_rotate_left)
                   | (op == xma_pkg::far_rotate_left_to_working)
                   | (op == xma_pkg::far_rotate_left_through_carry)
                   | (op == xma_pkg::far_rotate_left_carry_to_working);
   assign rot_through = (op == xma_pkg::far_rotate_left_through_carry)
                      | (op == xma_pkg::far_rotate_left_carry_to_working)
                      | (op == xma_pkg::far_rotate_right_through_carry)
                      | (op == xma_pkg::far_rotate_right_carry_to_working);

   xma_rotator #(
      .W(W)
   ) u_rotator (
      .d_i(operand),
      .cin_i(flags.carry_flag),
      .left_i(rot_left),
      .through_i(rot_through),
      .res_o(rot_res),
      .cout_o(rot_cout)
   );

   // decimal adjust judges both nibbles of the unadjusted value
   assign daa_lo = (working[`XMA_NIB_W-1:0] > `XMA_BCD_MAX) | flags.half_carry_flag;
   assign daa_hi = (working[W-1:`XMA_NIB_W] > `XMA_BCD_MAX) | flags.carry_flag;
   assign daa_add = (daa_lo ? `XMA_DAA_LO : `XMA_BYTE_ZERO)
                  | (daa_hi ? `XMA_DAA_HI : `XMA_BYTE_ZERO);
   assign daa_sum = {1'b0, working} + {1'b0, daa_add};
   assign inc_res = operand + `XMA_BYTE_ONE;
   assign dec_res = operand - `XMA_BYTE_ONE;
   assign bit_mask = `XMA_BYTE_ONE << bit_idx;
   assign res_zero = (res == `XMA_BYTE_ZERO);

   // result select, destination and flag update per operation
   always_comb begin
      res = operand;
      to_mem = 1'b0;
      to_working = 1'b0;
      next_flags = flags;
      case (op)
         xma_pkg::far_add_with_carry_to_working,
         xma_pkg::far_add_to_working,
         xma_pkg::far_subtract_with_borrow: begin
            res = as_res;
            to_working = 1'b1;
         end
         xma_pkg::far_add_with_carry_to_memory,
         xma_pkg::far_add_to_memory: begin
            res = as_res;
            to_mem = 1'b1;
         end
         xma_pkg::far_bitwise_conjunction: begin
            res = working & operand;
            to_working = 1'b1;
         end
         xma_pkg::far_bitwise_conjunction_to_memory: begin
            res = working & operand;
            to_mem = 1'b1;
         end
         xma_pkg::far_bitwise_disjunction: begin
            res = working | operand;
            to_working = 1'b1;
         end
         xma_pkg::far_bitwise_disjunction_to_memory: begin
            res = working | operand;
            to_mem = 1'b1;
         end
         xma_pkg::far_byte_clear: begin
            res = `XMA_BYTE_ZERO;
            to_mem = 1'b1;
         end
         xma_pkg::far_bit_clear: begin
            res = operand & ~bit_mask;
            to_mem = 1'b1;
         end
         xma_pkg::far_invert_in_place: begin
            res = ~operand;
            to_mem = 1'b1;
         end
         xma_pkg::far_invert_to_working: begin
            res = ~operand;
            to_working = 1'b1;
         end
         xma_pkg::far_decimal_adjust_to_memory: begin
            res = daa_sum[W-1:0];
            to_mem = 1'b1;
            // carry may only be raised, so chained bcd sums keep their carry
            next_flags.carry_flag = flags.carry_flag | daa_sum[W];
         end
         xma_pkg::far_decrement_in_place: begin
            res = dec_res;
            to_mem = 1'b1;
         end
         xma_pkg::far_decrement_to_working: begin
            res = dec_res;
            to_working = 1'b1;
         end
         xma_pkg::far_increment_in_place: begin
            res = inc_res;
            to_mem = 1'b1;
         end
         xma_pkg::far_increment_to_working: begin
            res = inc_res;
            to_working = 1'b1;
         end
         xma_pkg::far_move_to_working: begin
            res = operand;
            to_working = 1'b1;
         end
         xma_pkg::far_move_to_memory: begin
            res = working;
            to_mem = 1'b1;
         end
         xma_pkg::far_rotate_left,
         xma_pkg::far_rotate_right: begin
            res = rot_res;
            to_mem = 1'b1;
         end
         xma_pkg::far_rotate_left_to_working,
         xma_pkg::far_rotate_right_to_working: begin
            res = rot_res;
            to_working = 1'b1;
         end
         xma_pkg::far_rotate_left_through_carry,
         xma_pkg::far_rotate_right_through_carry: begin
            res = rot_res;
            to_mem = 1'b1;
            next_flags.carry_flag = rot_cout;
         end
         xma_pkg::far_rotate_left_carry_to_working,
         xma_pkg::far_rotate_right_carry_to_working: begin
            res = rot_res;
            to_working = 1'b1;
            next_flags.carry_flag = rot_cout;
         end
         default: begin
            res = operand;
         end
      endcase
      // arithmetic group updates carry, half carry, overflow, sign and zero
      if ((op == xma_pkg::far_add_with_carry_to_working) || (op == xma_pkg::far_add_with_carry_to_memory)
          || (op == xma_pkg::far_add_to_working) || (op == xma_pkg::far_add_to_memory) || as_sub) begin
         next_flags.carry_flag = as_c;
         next_flags.half_carry_flag = as_ac;
         next_flags.overflow_flag = as_ov;
         next_flags.signed_result_flag = as_sc;
         next_flags.zero_flag = res_zero;
      end
      // chained zero holds only if this and the previous byte were zero
      if (as_sub) begin
         next_flags.chained_zero_flag = res_zero & flags.zero_flag;
      end
      // logic, complement, increment and decrement touch only zero
      if ((op == xma_pkg::far_bitwise_conjunction) || (op == xma_pkg::far_bitwise_conjunction_to_memory)
          || (op == xma_pkg::far_bitwise_disjunction) || (op == xma_pkg::far_bitwise_disjunction_to_memory)
          || (op == xma_pkg::far_invert_in_place) || (op == xma_pkg::far_invert_to_working)
          || (op == xma_pkg::far_decrement_in_place) || (op == xma_pkg::far_decrement_to_working)
          || (op == xma_pkg::far_increment_in_place) || (op == xma_pkg::far_increment_to_working)) begin
         next_flags.zero_flag = res_zero;
      end
   end

   // working register and flags: datapath or software, never both
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         working <= `XMA_RST_BYTE;
         flags <= `XMA_RST_FLAGS;
      end else if (exec) begin
         flags <= next_flags;
         if (to_working) begin
            working <= res;
         end
      end else begin
         if (sw_wreg_wr) begin
            working <= wb_req_i.dat[W-1:0];
         end
         if (sw_flags_wr) begin
            flags <= wb_req_i.dat[$bits(flags)-1:0];
         end
      end
   end

   // data memory, no reset: contents are undefined until written
   always_ff @(posedge clk_sys_i) begin
      if (exec & to_mem) begin
         mem[far_addr] <= res;
      end else if (sw_mem_wr) begin
         mem[far_addr] <= wb_req_i.dat[W-1:0];
      end
   end

endmodule
`default_nettype wire

// ==== verification/xma_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "xma_defines.svh"
module xma_props (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // watched ports
   input wire xma_pkg::xma_wb_req_t wb_req_i,
   input wire logic [`XMA_WB_DW-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic busy_o,
   input wire logic done_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // request taken at this edge; a start needs lane 0
   wire logic tk = wb_req_i.cyc & wb_req_i.stb & !wb_ack_o;
   wire logic rd_tk = tk & !wb_req_i.we;
   wire logic go = tk & wb_req_i.we & wb_req_i.sel[0] & (wb_req_i.adr == `XMA_OFS_CTRL);
   ack_answer_a: assert property (tk |=> wb_ack_o)
      else $error("request not acked next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   wreg_width_a: assert property (rd_tk && wb_req_i.adr == `XMA_OFS_WREG |=> wb_dat_o[31:8] == 24'h0)
      else $error("working register wider than a byte");
   op_start_a: assert property (go && !busy_o |=> busy_o [*2] ##1 !busy_o)
      else $error("operation length wrong");
   busy_cause_a: assert property (!busy_o && !go |=> !busy_o)
      else $error("busy without start");
   done_end_a: assert property ($fell(busy_o) |-> done_o)
      else $error("no done when busy ends");
   done_pulse_a: assert property (done_o |-> $past(busy_o) && !busy_o ##1 !done_o)
      else $error("done out of place");
   stat_idle_a: assert property (rd_tk && wb_req_i.adr == `XMA_OFS_STAT && !busy_o |=> wb_dat_o == 32'h0)
      else $error("status busy while idle");
endmodule
bind xma_top xma_props u_xma_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// ==== verification/xma_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module xma_host (
   // clock
   input wire logic clk_sys_i,
   // bus
   output var xma_pkg::xma_wb_req_t req_o,
   input wire logic ack_i,
   input wire logic [31:0] dat_i
);
   initial req_o = '0;
   // held until ack is sampled, then idle one cycle so no stb glues onto the next
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
      req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: d};
      @(posedge clk_sys_i);
      while (ack_i !== 1'b1) @(posedge clk_sys_i);
      q = dat_i;
      req_o <= '0;
      @(posedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "xma_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
   // clock, reset and bus
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   xma_pkg::xma_wb_req_t wb_req;
   logic [31:0] wb_dat;
   logic wb_ack;
   logic busy;
   logic done;
   logic [8:0] far_adr = 9'h005;
   logic [31:0] q;
   int error_cnt = 0;
   int n_tests = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   xma_top u_xma_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack), .busy_o(busy), .done_o(done));
   xma_host u_host (.clk_sys_i(clk_sys_i), .req_o(wb_req), .ack_i(wb_ack), .dat_i(wb_dat));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, q);
   endtask
   // load operands, start, wait for done, read all three results back
   task automatic do_op(input logic [7:0] c, w, f, m, ew, ef, em);
      int i = 0;
      wr(`XMA_OFS_ADDR, {23'h0, far_adr});
      wr(`XMA_OFS_MDATA, {24'h0, m});
      wr(`XMA_OFS_WREG, {24'h0, w});
      wr(`XMA_OFS_FLAGS, {24'h0, f});
      wr(`XMA_OFS_CTRL, {24'h0, c});
      do begin
         @(posedge clk_sys_i);
         i++;
      end while (done !== 1'b1 && i < 20);
      // a wait that ran out shows up here as a missing done
      `CHK(done, 1'b1)
      `CHK(busy, 1'b0)
      rd(`XMA_OFS_WREG);
      `CHK(q, {24'h0, ew})
      rd(`XMA_OFS_FLAGS);
      `CHK(q, {24'h0, ef})
      rd(`XMA_OFS_MDATA);
      `CHK(q, {24'h0, em})
   endtask
   // reset values and an unmapped hole
   task automatic t_reset();
      rd(`XMA_OFS_WREG);
      `CHK(q, 32'h0)
      rd(`XMA_OFS_FLAGS);
      `CHK(q, 32'h0)
      rd(`XMA_OFS_STAT);
      `CHK(q, 32'h0)
      wr(8'h40, 32'hffffffff);
      rd(8'h40);
      `CHK(q, 32'h0)
   endtask
   task automatic t_add();
      do_op(8'h02, 8'h48, 8'h00, 8'h39, 8'h81, 8'h0a, 8'h39);
      do_op(8'h03, 8'h80, 8'h00, 8'h80, 8'h80, 8'h1d, 8'h00);
      do_op(8'h00, 8'h10, 8'h01, 8'h20, 8'h31, 8'h00, 8'h20);
      do_op(8'h01, 8'hff, 8'h01, 8'h00, 8'hff, 8'h07, 8'h00);
   endtask
   task automatic t_logic();
      do_op(8'h04, 8'hf0, 8'h3b, 8'h0f, 8'h00, 8'h3f, 8'h0f);
      do_op(8'h05, 8'h3c, 8'h3f, 8'hf0, 8'h3c, 8'h3b, 8'h30);
      do_op(8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00);
      do_op(8'h12, 8'h81, 8'h04, 8'h42, 8'h81, 8'h00, 8'hc3);
      do_op(8'h08, 8'h11, 8'h00, 8'hff, 8'h11, 8'h04, 8'h00);
      do_op(8'h09, 8'h11, 8'h3f, 8'h5a, 8'ha5, 8'h3b, 8'h5a);
   endtask
   task automatic t_clear();
      do_op(8'h06, 8'h11, 8'h3f, 8'ha5, 8'h11, 8'h3f, 8'h00);
      do_op(8'he7, 8'h11, 8'h15, 8'hff, 8'h11, 8'h15, 8'h7f);
      do_op(8'h07, 8'h11, 8'h15, 8'hff, 8'h11, 8'h15, 8'hfe);
   endtask
   // the fix is chosen on the unadjusted byte
   task automatic t_daa();
      do_op(8'h0a, 8'h9a, 8'h00, 8'h33, 8'h9a, 8'h00, 8'ha0);
      do_op(8'h0a, 8'haa, 8'h3a, 8'h33, 8'haa, 8'h3b, 8'h10);
      do_op(8'h0a, 8'h12, 8'h02, 8'h33, 8'h12, 8'h02, 8'h18);
      do_op(8'h0a, 8'h00, 8'h01, 8'h33, 8'h00, 8'h01, 8'h60);
   endtask
   task automatic t_incdec();
      do_op(8'h0b, 8'h11, 8'h00, 8'h01, 8'h11, 8'h04, 8'h00);
      do_op(8'h0c, 8'h11, 8'h3f, 8'h00, 8'hff, 8'h3b, 8'h00);
      do_op(8'h0d, 8'h11, 8'h01, 8'hff, 8'h11, 8'h05, 8'h00);
      do_op(8'h0e, 8'h11, 8'h04, 8'h7f, 8'h80, 8'h00, 8'h7f);
   endtask
   task automatic t_move();
      do_op(8'h0f, 8'h00, 8'h3f, 8'hc3, 8'hc3, 8'h3f, 8'hc3);
      do_op(8'h10, 8'h5a, 8'h00, 8'h00, 8'h5a, 8'h00, 8'h5a);
   endtask
   task automatic t_rotate();
      do_op(8'h13, 8'h11, 8'h3f, 8'h81, 8'h11, 8'h3f, 8'h03);
      do_op(8'h14, 8'h11, 8'h00, 8'h81, 8'h03, 8'h00, 8'h81);
      do_op(8'h15, 8'h11, 8'h3e, 8'h81, 8'h11, 8'h3f, 8'h02);
      do_op(8'h16, 8'h11, 8'h3f, 8'h40, 8'h81, 8'h3e, 8'h40);
      do_op(8'h17, 8'h11, 8'h3f, 8'h81, 8'h11, 8'h3f, 8'hc0);
      do_op(8'h18, 8'h11, 8'h00, 8'h01, 8'h80, 8'h00, 8'h01);
      do_op(8'h19, 8'h11, 8'h3e, 8'h81, 8'h11, 8'h3f, 8'h40);
      do_op(8'h1a, 8'h11, 8'h3f, 8'h02, 8'h81, 8'h3e, 8'h02);
   endtask
   task automatic t_sub();
      do_op(8'h1b, 8'h05, 8'h01, 8'h03, 8'h02, 8'h03, 8'h03);
      do_op(8'h1b, 8'h00, 8'h04, 8'h00, 8'hff, 8'h10, 8'h00);
      do_op(8'h1b, 8'h05, 8'h05, 8'h05, 8'h00, 8'h27, 8'h05);
      do_op(8'h1b, 8'h05, 8'h01, 8'h05, 8'h00, 8'h07, 8'h05);
      do_op(8'h1b, 8'h80, 8'h01, 8'h01, 8'h7f, 8'h19, 8'h01);
   endtask
   // same offset in the other section must stay untouched
   task automatic t_section();
      wr(`XMA_OFS_ADDR, 32'h005);
      wr(`XMA_OFS_MDATA, 32'h22);
      far_adr = 9'h105;
      do_op(8'h0d, 8'h11, 8'h00, 8'h11, 8'h11, 8'h00, 8'h12);
      wr(`XMA_OFS_ADDR, 32'h005);
      rd(`XMA_OFS_MDATA);
      `CHK(q, 32'h22)
      far_adr = 9'h005;
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // about 960 cycles expected
   initial begin
      repeat (6000) @(posedge clk_sys_i);
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      t_reset();
      t_add();
      t_logic();
      t_clear();
      t_daa();
      t_incdec();
      t_move();
      t_rotate();
      t_sub();
      t_section();
      stop_test();
   end
endmodule
`default_nettype wire
